// ---- src/mic_ref_pkg.sv ----
// Purpose: Shared constants and types of the mic/reference gain, delay and output mux block
// Assumes: 16-bit signed samples, APB with 32-bit data and byte addresses
// Notes: Register offsets and field positions are used by design and bench alike
package mic_ref_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int MIC_COUNT = 4;
  localparam int DELAY_DEPTH = 64;
  localparam int DELAY_IDX_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int GAIN_FRAC = 12;
  localparam int ADDR_W = 8;

  typedef logic signed [15:0] sample_type;
  typedef struct packed {
    sample_type [3:0] ch;
  } micFrame_type;
  typedef struct packed {
    sample_type left;
    sample_type right;
  } outPair_type;
  localparam int PAIR_W = 32;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_LEFT_SEL = 8'h00;
  localparam logic [7:0] ADDR_RIGHT_SEL = 8'h04;
  localparam logic [7:0] ADDR_RAISE_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_REF_GAIN = 8'h0C;
  localparam logic [7:0] ADDR_MIC_GAIN = 8'h10;
  localparam logic [7:0] ADDR_ALIGN_DELAY = 8'h14;
  localparam logic [7:0] ADDR_CONFIG = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // Source selector fields
  localparam int SEL_CAT_LSB = 0;
  localparam int SEL_IDX_LSB = 8;
  // Raise flags: bit 0 left, bit 1 right
  localparam int RAISE_LEFT_BIT = 0;
  localparam int RAISE_RIGHT_BIT = 1;
  // Config: bit 0 output bus at 48 kHz
  localparam int CFG_BUS48_BIT = 0;
  // Status fields
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_MICNEW_BIT = 4;
  localparam int STAT_DLYNEG_BIT = 5;
  localparam int STAT_DLYMAG_LSB = 8;

  // ****************************************
  // Source categories
  // ****************************************
  localparam logic [3:0] SRC_MIC_RAW = 4'h1;
  localparam logic [3:0] SRC_MIC_ALIGNED = 4'h3;
  localparam logic [3:0] SRC_REF_PRE = 4'h4;
  localparam logic [3:0] SRC_REF_ALIGNED = 4'h5;
  localparam logic [3:0] SRC_REF_POST = 4'hC;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [15:0] GAIN_UNITY = 16'h1000;
  localparam logic [1:0] RAISE_RESET = 2'h3;
  localparam logic CFG_BUS48_RESET = 1'b1;
  localparam logic [7:0] DELAY_RESET = 8'h00;
  localparam logic [3:0] SEL_CAT_RESET = 4'h0;
  localparam logic [1:0] SEL_IDX_RESET = 2'h0;
  localparam logic [6:0] DELAY_MAX = 7'h3F;
  localparam sample_type SAMPLE_MAX = 16'sh7FFF;
  localparam sample_type SAMPLE_MIN = -16'sh8000;
  localparam sample_type SAMPLE_ZERO = 16'sh0000;

endpackage

// ---- src/sample_fifo.sv ----
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes: Simultaneous push and pop allowed when neither empty nor full
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = level != (PTR_W+1)'(DEPTH);
  assign outValid = level != '0;
  assign outData = store[rdPtr];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        store[wrPtr] <= inData;
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      level <= level + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- src/mic_ref_gain_delay_mux.sv ----
// Purpose: Gain, alignment delay and two-channel output mux for four mics and a reference
// Assumes: refValid marks one output-bus sample; micValid one 16 kHz mic frame
// Notes: Gains and delay written over APB load at the next accepted reference sample and apply from the one after it; other registers act at once
// Notes on behaviour
// - Category 1 index n routes raw mic n to that output.
// - Category 4 is the reference before its gain, category 12 the reference after it.
// - At reset the reference gain is unity so pre- and post-gain taps match.
// - Reference gain is internal and the speaker feed stays untouched.
// - One common mic gain is applied to all four mics.
// - Category 3 index n is mic n after gain and alignment delay.
// - Mics run at 16 kHz and pass an upsampler on a 48 kHz bus per output flag.
// - A positive alignment delay delays the reference by that many samples.
// - A negative alignment delay delays every mic by its magnitude.
// - Category 5 index 0 is the reference after gain and alignment delay.
// - Left and right outputs have independent source selectors.
// - Upsample flags reset to 1 with the bus set to 48 kHz.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mic_ref_gain_delay_mux (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mic_ref_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Microphone input, one frame per 16 kHz sample
  input wire logic micValid,
  input wire mic_ref_pkg::micFrame_type micIn,
  // Reference input, one sample per output-bus sample
  input wire logic refValid,
  output logic refReady,
  input wire mic_ref_pkg::sample_type refIn,
  // Speaker feed, reference as received
  output logic speakerValid,
  output mic_ref_pkg::sample_type speakerOut,
  // Output pair stream
  output logic outValid,
  input wire logic outReady,
  output mic_ref_pkg::outPair_type outPair
);
  import mic_ref_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic sample_type applyGain(input sample_type s, input logic [15:0] g);
    logic signed [32:0] p;
    p = s * $signed({1'b0, g});
    p = p >>> GAIN_FRAC;
    if (p > 33'(SAMPLE_MAX)) begin
      applyGain = SAMPLE_MAX;
    end else if (p < 33'(SAMPLE_MIN)) begin
      applyGain = SAMPLE_MIN;
    end else begin
      applyGain = p[15:0];
    end
  endfunction

  function automatic logic [DELAY_IDX_W-1:0] tapIndex(input logic [DELAY_IDX_W-1:0] wr,
                                                     input logic [6:0] mag);
    tapIndex = wr - mag[DELAY_IDX_W-1:0];
  endfunction

  function automatic logic [6:0] delayMagnitude(input logic [7:0] d);
    logic [7:0] m;
    m = d[7] ? 8'(-d) : d;
    delayMagnitude = (m > {1'b0, DELAY_MAX}) ? DELAY_MAX : m[6:0];
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  // Software-visible copies
  logic [3:0] leftCat;
  logic [1:0] leftIdx;
  logic [3:0] rightCat;
  logic [1:0] rightIdx;
  logic [1:0] raiseFlags;
  logic [15:0] refGain;
  logic [15:0] micGain;
  logic [7:0] alignDelay;
  logic bus48;
  // Working copies, loaded only at a sample boundary
  logic [15:0] activeRefGain;
  logic [15:0] activeMicGain;
  logic [7:0] activeDelay;
  logic [31:0] readWord;

  // ****************************************
  // APB decode
  // ****************************************
  wire setupPhase = psel && !penable;
  wire accessPhase = psel && penable;
  wire hitLeft = paddr == ADDR_LEFT_SEL;
  wire hitRight = paddr == ADDR_RIGHT_SEL;
  wire hitRaise = paddr == ADDR_RAISE_FLAGS;
  wire hitRefGain = paddr == ADDR_REF_GAIN;
  wire hitMicGain = paddr == ADDR_MIC_GAIN;
  wire hitDelay = paddr == ADDR_ALIGN_DELAY;
  wire hitConfig = paddr == ADDR_CONFIG;
  wire hitStatus = paddr == ADDR_STATUS;
  wire hitAny = hitLeft || hitRight || hitRaise || hitRefGain || hitMicGain || hitDelay
                || hitConfig || hitStatus;
  // Status is read-only, so a write to it is refused
  wire writeOk = accessPhase && pwrite && hitAny && !hitStatus;

  assign pready = accessPhase;
  assign pslverr = accessPhase && (!hitAny || (pwrite && hitStatus));

  // ****************************************
  // Datapath wiring
  // ****************************************
  logic fifoInReady;
  logic [2:0] fifoLevel;
  logic micNew;
  sample_type micRaw [MIC_COUNT];
  sample_type micAligned [MIC_COUNT];
  sample_type refLine [DELAY_DEPTH];
  sample_type micLine [MIC_COUNT][DELAY_DEPTH];
  logic [DELAY_IDX_W-1:0] refWr;
  logic [DELAY_IDX_W-1:0] micWr;

  wire frameGo = refValid && fifoInReady;
  assign refReady = fifoInReady;

  wire delayNeg = activeDelay[7];
  wire [6:0] delayMag = delayMagnitude(activeDelay);
  wire refDelayOn = !delayNeg && delayMag != '0;
  wire micDelayOn = delayNeg && delayMag != '0;

  wire sample_type refPost = applyGain(refIn, activeRefGain);
  wire sample_type refAligned = refDelayOn ? refLine[tapIndex(refWr, delayMag)] : refPost;

  sample_type micPost [MIC_COUNT];
  sample_type micDelayedNow [MIC_COUNT];
  for (genvar i = 0; i < MIC_COUNT; i++) begin : g_mic
    assign micPost[i] = applyGain(micIn.ch[i], activeMicGain);
    assign micDelayedNow[i] = micDelayOn ? micLine[i][tapIndex(micWr, delayMag)] : micPost[i];
  end

  // ****************************************
  // Output mux
  // ****************************************
  function automatic sample_type selectTap(input logic [3:0] cat, input logic [1:0] idx,
                                           input logic raise, input logic busFast,
                                           input sample_type mRaw [MIC_COUNT],
                                           input sample_type mAl [MIC_COUNT],
                                           input logic fresh, input sample_type rPre,
                                           input sample_type rPost, input sample_type rAl);
    logic slowSrc;
    sample_type v;
    slowSrc = 1'b0;
    case (cat)
      SRC_MIC_RAW: begin
        v = mRaw[idx];
        slowSrc = 1'b1;
      end
      SRC_MIC_ALIGNED: begin
        v = mAl[idx];
        slowSrc = 1'b1;
      end
      SRC_REF_PRE: v = rPre;
      SRC_REF_POST: v = rPost;
      SRC_REF_ALIGNED: v = (idx == 2'h0) ? rAl : SAMPLE_ZERO;
      default: v = SAMPLE_ZERO;
    endcase
    // Upsampler: hold the 16 kHz value across bus samples, or zero-stuff with the flag clear
    if (slowSrc && busFast && !raise && !fresh) begin
      v = SAMPLE_ZERO;
    end
    selectTap = v;
  endfunction

  wire sample_type leftTap = selectTap(leftCat, leftIdx, raiseFlags[RAISE_LEFT_BIT], bus48, micRaw,
                                       micAligned, micNew, refIn, refPost, refAligned);
  wire sample_type rightTap = selectTap(rightCat, rightIdx, raiseFlags[RAISE_RIGHT_BIT], bus48, micRaw,
                                        micAligned, micNew, refIn, refPost, refAligned);
  wire outPair_type pairNow = '{left: leftTap, right: rightTap};

  // ****************************************
  // Register writes and sample-boundary loading
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      leftCat <= SEL_CAT_RESET;
      leftIdx <= SEL_IDX_RESET;
      rightCat <= SEL_CAT_RESET;
      rightIdx <= SEL_IDX_RESET;
      raiseFlags <= RAISE_RESET;
      refGain <= GAIN_UNITY;
      micGain <= GAIN_UNITY;
      alignDelay <= DELAY_RESET;
      bus48 <= CFG_BUS48_RESET;
    end else if (writeOk) begin
      if (hitLeft) begin
        leftCat <= pwdata[SEL_CAT_LSB +: 4];
        leftIdx <= pwdata[SEL_IDX_LSB +: 2];
      end
      if (hitRight) begin
        rightCat <= pwdata[SEL_CAT_LSB +: 4];
        rightIdx <= pwdata[SEL_IDX_LSB +: 2];
      end
      if (hitRaise) begin
        raiseFlags <= pwdata[1:0];
      end
      if (hitRefGain) begin
        refGain <= pwdata[15:0];
      end
      if (hitMicGain) begin
        micGain <= pwdata[15:0];
      end
      if (hitDelay) begin
        alignDelay <= pwdata[7:0];
      end
      if (hitConfig) begin
        bus48 <= pwdata[CFG_BUS48_BIT];
      end
    end
  end

  // Gains and delay move only between samples, so no sample mixes old and new settings
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      activeRefGain <= GAIN_UNITY;
      activeMicGain <= GAIN_UNITY;
      activeDelay <= DELAY_RESET;
    end else if (frameGo) begin
      activeRefGain <= refGain;
      activeMicGain <= micGain;
      activeDelay <= alignDelay;
    end
  end

  // ****************************************
  // APB read data
  // ****************************************
  always_comb begin
    readWord = '0;
    case (1'b1)
      hitLeft: begin
        readWord[SEL_CAT_LSB +: 4] = leftCat;
        readWord[SEL_IDX_LSB +: 2] = leftIdx;
      end
      hitRight: begin
        readWord[SEL_CAT_LSB +: 4] = rightCat;
        readWord[SEL_IDX_LSB +: 2] = rightIdx;
      end
      hitRaise: readWord[1:0] = raiseFlags;
      hitRefGain: readWord[15:0] = refGain;
      hitMicGain: readWord[15:0] = micGain;
      hitDelay: readWord[7:0] = alignDelay;
      hitConfig: readWord[CFG_BUS48_BIT] = bus48;
      hitStatus: begin
        readWord[STAT_LEVEL_LSB +: 3] = fifoLevel;
        readWord[STAT_MICNEW_BIT] = micNew;
        readWord[STAT_DLYNEG_BIT] = delayNeg;
        readWord[STAT_DLYMAG_LSB +: 7] = delayMag;
      end
      default: readWord = '0;
    endcase
  end

  // Captured in the setup cycle so the access cycle answers from a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setupPhase && !pwrite) begin
      prdata <= readWord;
    end
  end

  // ****************************************
  // Reference delay line and speaker feed
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refWr <= '0;
      speakerValid <= 1'b0;
      speakerOut <= SAMPLE_ZERO;
      for (int k = 0; k < DELAY_DEPTH; k++) begin
        refLine[k] <= SAMPLE_ZERO;
      end
    end else begin
      speakerValid <= frameGo;
      if (frameGo) begin
        speakerOut <= refIn;
        refLine[refWr] <= refPost;
        refWr <= refWr + 1'b1;
      end
    end
  end

  // ****************************************
  // Microphone delay lines and hold registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      micWr <= '0;
      for (int i = 0; i < MIC_COUNT; i++) begin
        micRaw[i] <= SAMPLE_ZERO;
        micAligned[i] <= SAMPLE_ZERO;
        for (int k = 0; k < DELAY_DEPTH; k++) begin
          micLine[i][k] <= SAMPLE_ZERO;
        end
      end
    end else if (micValid) begin
      micWr <= micWr + 1'b1;
      for (int i = 0; i < MIC_COUNT; i++) begin
        micRaw[i] <= micIn.ch[i];
        micAligned[i] <= micDelayedNow[i];
        micLine[i][micWr] <= micPost[i];
      end
    end
  end

  // New mic frame wins over its consumption in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      micNew <= 1'b0;
    end else if (micValid) begin
      micNew <= 1'b1;
    end else if (frameGo) begin
      micNew <= 1'b0;
    end
  end

  // ****************************************
  // Output buffer
  // ****************************************
  sample_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(refValid),
    .inReady(fifoInReady),
    .inData(pairNow),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outPair),
    .level(fifoLevel)
  );

endmodule
`default_nettype wire

// ---- dv/mic_ref_gain_delay_mux_chk.sv ----
// Purpose: Port assertions for the gain, delay and output mux block
// Assumes: Shadow selector categories and reference gain follow APB writes
// Notes: Pair checks fire only when the pushed pair lands at the FIFO head
`timescale 1ns/1ps
`default_nettype none
module mic_ref_gain_delay_mux_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mic_ref_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic refValid,
  input wire logic refReady,
  input wire mic_ref_pkg::sample_type refIn,
  input wire logic speakerValid,
  input wire mic_ref_pkg::sample_type speakerOut,
  input wire logic outValid,
  input wire logic outReady,
  input wire mic_ref_pkg::outPair_type outPair
);
  import mic_ref_pkg::*;
  logic [3:0] leftCat, rightCat;
  logic [15:0] gainPend, gainAct;
  logic [2:0] cnt;
  wire logic wr = psel && penable && pwrite;
  wire logic accept = refValid && refReady;
  wire logic pop = outValid && outReady;
  wire logic [2:0] next_cnt = cnt + {2'h0, accept} - {2'h0, pop};
  // Pending gain becomes active only on an accepted sample
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      leftCat <= 4'h0;
      rightCat <= 4'h0;
      gainPend <= GAIN_UNITY;
      gainAct <= GAIN_UNITY;
      cnt <= 3'h0;
    end else begin
      if (wr && paddr == ADDR_LEFT_SEL) leftCat <= pwdata[3:0];
      if (wr && paddr == ADDR_RIGHT_SEL) rightCat <= pwdata[3:0];
      if (wr && paddr == ADDR_REF_GAIN) gainPend <= pwdata[15:0];
      if (accept) gainAct <= gainPend;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_push;
    refValid && refReady && !outValid;
  endsequence
  property p_readyAccess;
    psel && !penable ##1 psel && penable |-> pready;
  endproperty
  a_readyAccess: assert property (p_readyAccess) else $error("no ready in access phase");
  property p_errRefused;
    psel && penable && (paddr > 8'h1C || (pwrite && paddr == ADDR_STATUS)) |-> pslverr;
  endproperty
  a_errRefused: assert property (p_errRefused) else $error("refused access without error");
  property p_speaker;
    refValid && refReady |=> speakerValid && speakerOut == $past(refIn);
  endproperty
  a_speaker: assert property (p_speaker) else $error("speaker feed altered");
  property p_speakerIdle;
    !(refValid && refReady) |=> !speakerValid;
  endproperty
  a_speakerIdle: assert property (p_speakerIdle) else $error("speaker pulse without sample");
  property p_refPre;
    (leftCat == SRC_REF_PRE) ##0 s_push |=> outValid && outPair.left == $past(refIn);
  endproperty
  a_refPre: assert property (p_refPre) else $error("pre-gain tap wrong");
  property p_postUnity;
    (leftCat == SRC_REF_PRE && rightCat == SRC_REF_POST && gainPend == GAIN_UNITY && gainAct == GAIN_UNITY)
      ##0 s_push |=> outPair.left == outPair.right;
  endproperty
  a_postUnity: assert property (p_postUnity) else $error("unity gain taps differ");
  property p_zeroCat;
    (rightCat == 4'h0) ##0 s_push |=> outPair.right == SAMPLE_ZERO;
  endproperty
  a_zeroCat: assert property (p_zeroCat) else $error("right output not its own selection");
  property p_fifoLevel;
    refReady == (cnt != 3'h4) && outValid == (cnt != 3'h0);
  endproperty
  a_fifoLevel: assert property (p_fifoLevel) else $error("fifo flags disagree with level");
  property p_outHold;
    outValid && !outReady |=> outValid && $stable(outPair);
  endproperty
  a_outHold: assert property (p_outHold) else $error("pair changed while stalled");
endmodule
bind mic_ref_gain_delay_mux mic_ref_gain_delay_mux_chk u_mic_ref_gain_delay_mux_chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .refValid(refValid), .refReady(refReady), .refIn(refIn),
  .speakerValid(speakerValid), .speakerOut(speakerOut), .outValid(outValid), .outReady(outReady),
  .outPair(outPair));
`default_nettype wire

// ---- dv/host_audio_model.sv ----
// Purpose: Host audio bus: offers reference samples, sinks output pairs
// Assumes: Bench raises stall to hold the sink
// Notes: Released reference data shows the inverse, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module host_audio_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic refReady,
  input wire logic outValid,
  input wire mic_ref_pkg::outPair_type outPair,
  output logic refValid,
  output mic_ref_pkg::sample_type refIn,
  output logic outReady
);
  import mic_ref_pkg::*;
  outPair_type got [$];
  initial begin
    refValid = 1'b0;
    refIn = 16'sh5A5A;
    outReady = 1'b1;
  end
  always @(posedge sys_clk) begin
    if (outValid && outReady) got.push_back(outPair);
    outReady <= !stall;
  end
  task automatic sendRef(input sample_type s, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge sys_clk);
    refValid <= 1'b1;
    refIn <= s;
    for (n = 0; n < 100 && !ok; n++) begin
      @(posedge sys_clk);
      ok = refReady;
    end
    refValid <= 1'b0;
    refIn <= ~s;
  endtask
endmodule
`default_nettype wire

// ---- dv/mic_ref_gain_delay_mux_test.sv ----
// Purpose: Self-checking bench for the gain, delay and output mux block
// Assumes: Every gain and delay change is followed by one priming sample
// Notes: Expected pairs are hand-worked from Q4.12 gains
`timescale 1ns/1ps
`default_nettype none
module mic_ref_gain_delay_mux_test;
  import mic_ref_pkg::*;
  typedef struct packed {
    logic [31:0] l, r;
    logic [15:0] rg, mg, rs;
    logic [31:0] exp;
  } row_type;
  localparam micFrame_type F = 64'hFC00_0300_0200_0100;
  localparam micFrame_type G = 64'h1111_2222_3333_4444;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic micValid = 1'b0;
  micFrame_type micIn = 64'h0;
  logic stall = 1'b0;
  logic [31:0] prdata, q, pr;
  logic pready, pslverr, e, refValid, refReady, speakerValid, outValid, outReady;
  sample_type refIn, speakerOut;
  outPair_type outPair;
  bit ok;
  int compares = 0;
  int failures = 0;
  logic [7:0] rstA [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h00};
  logic [31:0] rstV [6] = '{32'h3, 32'h1000, 32'h1000, 32'h0, 32'h1, 32'h0};
  row_type rows [8] = '{
    '{32'h001, 32'h101, 16'h1000, 16'h1000, 16'h0000, 32'h0100_0200},
    '{32'h201, 32'h301, 16'h1000, 16'h1000, 16'h0000, 32'h0300_FC00},
    '{32'h004, 32'h00C, 16'h1000, 16'h1000, 16'h1234, 32'h1234_1234},
    '{32'h004, 32'h00C, 16'h2000, 16'h1000, 16'h1234, 32'h1234_2468},
    '{32'h003, 32'h303, 16'h1000, 16'h0800, 16'h0000, 32'h0080_FE00},
    '{32'h103, 32'h203, 16'h1000, 16'h0800, 16'h0000, 32'h0100_0180},
    '{32'h005, 32'h00C, 16'h2000, 16'h1000, 16'h7000, 32'h7FFF_7FFF},
    '{32'h105, 32'h000, 16'h1000, 16'h1000, 16'h4321, 32'h0000_0000}};
  always #50 sys_clk = ~sys_clk;
  mic_ref_gain_delay_mux u_mic_ref_gain_delay_mux (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .micValid(micValid), .micIn(micIn), .refValid(refValid), .refReady(refReady),
    .refIn(refIn), .speakerValid(speakerValid), .speakerOut(speakerOut), .outValid(outValid),
    .outReady(outReady), .outPair(outPair));
  host_audio_model u_host_audio_model (.sys_clk(sys_clk), .stall(stall), .refReady(refReady),
    .outValid(outValid), .outPair(outPair), .refValid(refValid), .refIn(refIn), .outReady(outReady));
  task automatic final_report;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    failures++;
    $display("BAD t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pull(input logic [31:0] exp, input bit cmp);
    int n;
    for (n = 0; n < 20 && u_host_audio_model.got.size() == 0; n++) @(posedge sys_clk);
    if (n == 20) hang();
    pr = u_host_audio_model.got.pop_front();
    if (cmp) chk(pr, exp);
  endtask
  task automatic refStep(input sample_type s, input logic [31:0] exp, input bit cmp);
    u_host_audio_model.sendRef(s, ok);
    if (!ok) hang();
    pull(exp, cmp);
  endtask
  task automatic mic(input micFrame_type f);
    @(posedge sys_clk);
    micValid <= 1'b1;
    micIn <= f;
    @(posedge sys_clk);
    micValid <= 1'b0;
    micIn <= ~f;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rstA[i], 32'h0);
      chk(q, rstV[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({q[31:1], e}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hFFFF);
    chk({31'h0, e}, 32'h1);
    $display("register test done");
    foreach (rows[i]) begin
      apb(1'b1, ADDR_LEFT_SEL, rows[i].l);
      apb(1'b1, ADDR_RIGHT_SEL, rows[i].r);
      apb(1'b1, ADDR_REF_GAIN, {16'h0, rows[i].rg});
      apb(1'b1, ADDR_MIC_GAIN, {16'h0, rows[i].mg});
      refStep(16'sh0, 32'h0, 1'b0);
      mic(F);
      refStep(rows[i].rs, rows[i].exp, 1'b1);
      chk({16'h0, speakerOut}, {16'h0, rows[i].rs});
    end
    $display("row test done");
    apb(1'b1, ADDR_LEFT_SEL, 32'h00C);
    apb(1'b1, ADDR_RIGHT_SEL, 32'h005);
    apb(1'b1, ADDR_ALIGN_DELAY, 32'h02);
    refStep(16'sh0, 32'h0, 1'b0);
    for (int k = 1; k < 5; k++) refStep(k[15:0] * 16'h0111, {k[15:0], k[15:0] - 16'h2} * 16'h0111, k > 2);
    apb(1'b1, ADDR_ALIGN_DELAY, 32'hFF);
    apb(1'b1, ADDR_LEFT_SEL, 32'h001);
    apb(1'b1, ADDR_RIGHT_SEL, 32'h003);
    refStep(16'sh0, 32'h0, 1'b0);
    mic(F);
    refStep(16'sh0, 32'h0, 1'b0);
    mic(G);
    refStep(16'sh0, 32'h4444_0100, 1'b1);
    $display("delay test done");
    apb(1'b1, ADDR_ALIGN_DELAY, 32'h00);
    apb(1'b1, ADDR_RIGHT_SEL, 32'h001);
    apb(1'b1, ADDR_RAISE_FLAGS, 32'h2);
    refStep(16'sh0, 32'h0, 1'b0);
    mic(F);
    refStep(16'sh0, 32'h0100_0100, 1'b1);
    refStep(16'sh0, 32'h0000_0100, 1'b1);
    apb(1'b1, ADDR_CONFIG, 32'h0);
    refStep(16'sh0, 32'h0100_0100, 1'b1);
    apb(1'b1, ADDR_CONFIG, 32'h1);
    apb(1'b1, ADDR_RAISE_FLAGS, 32'h3);
    $display("upsample test done");
    apb(1'b1, ADDR_LEFT_SEL, 32'h004);
    apb(1'b1, ADDR_RIGHT_SEL, 32'h000);
    stall <= 1'b1;
    for (int k = 1; k < 5; k++) begin
      u_host_audio_model.sendRef(k[15:0], ok);
      if (!ok) hang();
    end
    @(posedge sys_clk);
    chk({31'h0, refReady}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h4);
    stall <= 1'b0;
    for (int k = 1; k < 5; k++) pull({k[15:0], 16'h0}, 1'b1);
    $display("fifo test done");
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_LEFT_SEL, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, outValid}, 32'h0);
    $display("reset test done");
    final_report();
  end
endmodule
`default_nettype wire
